/* File: hw/hpad_regs.svh */
// Purpose: offsets, field positions and reset values of the host port
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef HPAD_REGS_SVH
`define HPAD_REGS_SVH
`define HPAD_OFS_DATA   3'h0
`define HPAD_OFS_IER    3'h1
`define HPAD_OFS_IIR    3'h2
`define HPAD_OFS_LCR    3'h3
`define HPAD_OFS_SPARE  3'h4
`define HPAD_OFS_LSR    3'h5
`define HPAD_OFS_MSR    3'h6
`define HPAD_OFS_ID     3'h7
`define HPAD_LCR_BANK   7
`define HPAD_RSTC_RXF   1
`define HPAD_RSTC_TXF   2
`define HPAD_RSTC_CPU   4
`define HPAD_IER_RDA    0
`define HPAD_IER_THRE   1
`define HPAD_IER_LS     2
`define HPAD_IER_MS     3
`define HPAD_MSR_RIRQ   4
`define HPAD_BAUD_RST   8'h00
`define HPAD_LCR_RST    8'h00
`define HPAD_IER_RST    4'h0
`define HPAD_IIR_NONE   8'h01
`define HPAD_IIR_LS     8'h06
`define HPAD_IIR_RDA    8'h04
`define HPAD_IIR_THRE   8'h02
`define HPAD_IIR_MS     8'h00
`endif

/* File: hw/hpad_pkg.sv */
// Purpose: shared types of the host port decode
// Assumes: nothing
// Notes:   constants live in hpad_regs.svh
package hpad_pkg;
  typedef struct packed {
    logic [9:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } hpad_bus_req_s;

  typedef struct packed {
    logic line_status;
    logic rx_avail;
    logic tx_empty;
    logic modem;
  } hpad_irq_src_s;

  typedef enum logic {
    HPAD_MODE_CHAR,
    HPAD_MODE_BLOCK
  } hpad_mode_e;
endpackage

/* File: hw/hpad_fifo.sv */
// Purpose: small valid/ready buffer in a data path
// Assumes: flush drops all entries at once
// Notes:   depth must be a power of two, at least two
`timescale 1ns/10ps
module hpad_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         flush_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("hpad_fifo: depth must be a power of two of at least two");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid_i && in_ready_o;
  wire           pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem[rp_q];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      // flush wins over a push in the same cycle
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? wp_q + 1'b1 : wp_q;
      rp_q  <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: hw/hpad_irq.sv */
// Purpose: interrupt priority and identification byte
// Assumes: sources arrive already masked by their enables
// Notes:   purely combinational
`timescale 1ns/10ps
`include "hpad_regs.svh"
module hpad_irq
  import hpad_pkg::*;
(
  // masked sources
  input  wire hpad_irq_src_s src_i,
  // identification
  output logic [7:0]         iir_o,
  output logic               pend_o
);
  // line status first, then receive, transmit, modem
  assign iir_o  = src_i.line_status ? `HPAD_IIR_LS   :    // [RL12]
                  src_i.rx_avail    ? `HPAD_IIR_RDA  :
                  src_i.tx_empty    ? `HPAD_IIR_THRE :
                  src_i.modem       ? `HPAD_IIR_MS   : `HPAD_IIR_NONE;
  assign pend_o = |src_i;
endmodule

/* File: hw/hpad_port.sv */
// Purpose: host I/O port decode and register map of a serial adapter card
// Assumes: host strobes are one-cycle pulses synchronous to sys_clk_i
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/10ps
`include "hpad_regs.svh"

// Contract
// RL1: answer only when address bits 3..9 match the base-address jumpers
// RL2: a fitted base jumper means zero, an absent one means one
// RL3: ten address lines; the low three pick one of eight registers
// RL4: host picks a base ending in 0 or 8, below 3FF, free of clashes
// RL5: all interrupt sources drive the one host line chosen by jumper
// RL6: option jumper 0 absent gives character mode, fitted gives response mode
// RL7: option jumper 1 has no effect
// RL8: read at offset 0 with bank bit clear pops the receive buffer
// RL9: write at offset 0 with bank bit clear pushes the transmit buffer
// RL10: with bank bit set, offset 0 is baud select and skips the buffers
// RL11: with bank bit clear, offset 1 is the interrupt enable register
// RL12: offset 2 reads interrupt identification and takes reset commands
// RL13: offset 3 is the read/write line control register
// RL14: offsets 5 and 6 are read-only line and modem status
// RL15: the bank bit is bit 7 of line control
// RL16: offset 7 reads a fixed card code; writes do nothing
// RL17: offset 4 reads zero; writes there or to read-only places are ignored
module hpad_port
  import hpad_pkg::*;
#(
  parameter int         IRQ_LINES = 8,
  parameter logic [7:0] CARD_ID   = 8'h5A   // arbitrary value
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  // host I/O bus
  input  wire hpad_bus_req_s        io_req_i,
  output logic [7:0]                io_rdata_o,
  output logic                      io_rdata_oe_o,
  // jumpers, high when fitted
  input  wire logic [6:0]           base_jumper_fitted_i,
  input  wire logic [IRQ_LINES-1:0] irq_route_fitted_i,
  input  wire logic [1:0]           option_jumper_fitted_i,
  // host interrupt lines
  output logic [IRQ_LINES-1:0]      irq_line_o,
  // card side receive stream and status
  input  wire logic                 rx_valid_i,
  output logic                      rx_ready_o,
  input  wire logic [7:0]           rx_data_i,
  input  wire logic                 rsp_complete_i,
  input  wire logic                 rx_overrun_i,
  input  wire logic                 rx_frame_err_i,
  input  wire logic                 remote_irq_i,
  // card side transmit stream
  output logic                      tx_valid_o,
  input  wire logic                 tx_ready_i,
  output logic [7:0]                tx_data_o,
  // card side configuration
  output hpad_mode_e                mode_o,
  output logic [7:0]                baud_sel_o,
  output logic [7:0]                line_ctrl_o,
  output logic                      card_reset_o
);
  if (IRQ_LINES < 1) begin : g_bad_irq
    $error("hpad_port: at least one interrupt line is needed");
  end

  logic [7:0] baud_q;
  logic [3:0] ier_q;
  logic [7:0] lcr_q;
  logic       ovr_q;
  logic       frm_q;
  logic [7:0] rdata_q;
  logic       rdata_oe_q;
  logic       card_rst_q;

  // address decode
  wire [6:0] base_val = ~base_jumper_fitted_i;                    // [RL2]
  wire       sel      = io_req_i.addr[9:3] == base_val;           // [RL1]
  wire [2:0] ofs      = io_req_i.addr[2:0];                       // [RL3]
  wire       bank     = lcr_q[`HPAD_LCR_BANK];                    // [RL15]
  wire       rd_hit   = sel && io_req_i.rd;
  wire       wr_hit   = sel && io_req_i.wr;
  wire [7:0] wdata    = io_req_i.wdata;

  // write strobes; anything not listed, such as offsets 4..7, is dropped
  wire wr_tx   = wr_hit && ofs == `HPAD_OFS_DATA && !bank;        // [RL9]
  wire wr_baud = wr_hit && ofs == `HPAD_OFS_DATA && bank;         // [RL10]
  wire wr_ier  = wr_hit && ofs == `HPAD_OFS_IER && !bank;         // [RL11]
  wire wr_rstc = wr_hit && ofs == `HPAD_OFS_IIR;                  // [RL12]
  wire wr_lcr  = wr_hit && ofs == `HPAD_OFS_LCR;                  // [RL13]

  // reset commands; the card reset only counts with the bank bit set
  wire cpu_rst  = wr_rstc && wdata[`HPAD_RSTC_CPU] && bank;
  wire rx_flush = cpu_rst || (wr_rstc && wdata[`HPAD_RSTC_RXF]);
  wire tx_flush = cpu_rst || (wr_rstc && wdata[`HPAD_RSTC_TXF]);

  // response mode hides bytes until the card marks a whole response
  assign mode_o = option_jumper_fitted_i[0] ? HPAD_MODE_BLOCK     // [RL6]
                                            : HPAD_MODE_CHAR;
  // option jumper 1 is left unread on purpose                    // [RL7]

  // receive path
  logic       rx_out_valid;
  logic [7:0] rx_out_data;
  wire        rx_avail = rx_out_valid &&
                         (mode_o == HPAD_MODE_CHAR || rsp_complete_i);
  wire        rd_rx    = rd_hit && ofs == `HPAD_OFS_DATA && !bank && rx_avail; // [RL8]
  wire        rd_lsr   = rd_hit && ofs == `HPAD_OFS_LSR;

  hpad_fifo #(
    .W     (8),
    .DEPTH (2)
  ) u_rx_buf (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (rx_flush),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .in_data_i   (rx_data_i),
    .out_valid_o (rx_out_valid),
    .out_ready_i (rd_rx),
    .out_data_o  (rx_out_data)
  );

  // transmit path; a full buffer shows as a clear empty flag, and
  // a write then is lost, as on any port of this kind
  logic tx_in_ready;

  hpad_fifo #(
    .W     (8),
    .DEPTH (2)
  ) u_tx_buf (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (tx_flush),
    .in_valid_i  (wr_tx),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (wdata),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (tx_data_o)
  );

  // status bytes
  wire [7:0] lsr_val = {1'b0, tx_in_ready && !tx_valid_o, tx_in_ready, 1'b0,
                        frm_q, 1'b0, ovr_q, rx_avail};            // [RL14]
  wire [7:0] msr_val = 8'(remote_irq_i) << `HPAD_MSR_RIRQ;        // [RL14]

  // interrupt sources, masked by their enables
  hpad_irq_src_s irq_src;
  logic [7:0]    iir_val;
  logic          irq_pend;

  assign irq_src.line_status = ier_q[`HPAD_IER_LS] && (ovr_q || frm_q);
  assign irq_src.rx_avail    = ier_q[`HPAD_IER_RDA] && rx_avail;
  assign irq_src.tx_empty    = ier_q[`HPAD_IER_THRE] && tx_in_ready;
  assign irq_src.modem       = ier_q[`HPAD_IER_MS] && remote_irq_i;

  hpad_irq u_irq (
    .src_i  (irq_src),
    .iir_o  (iir_val),
    .pend_o (irq_pend)
  );

  // no fitted jumper leaves every line quiet
  assign irq_line_o = {IRQ_LINES{irq_pend}} & irq_route_fitted_i; // [RL5]

  // read selection
  wire [7:0] rd_val =
    ofs == `HPAD_OFS_DATA ? (bank ? baud_q : rx_out_data) :       // [RL8] [RL10]
    ofs == `HPAD_OFS_IER  ? (bank ? 8'h00 : {4'h0, ier_q}) :      // [RL11]
    ofs == `HPAD_OFS_IIR  ? iir_val :                             // [RL12]
    ofs == `HPAD_OFS_LCR  ? lcr_q :                               // [RL13]
    ofs == `HPAD_OFS_LSR  ? lsr_val :
    ofs == `HPAD_OFS_MSR  ? msr_val :
    ofs == `HPAD_OFS_ID   ? CARD_ID : 8'h00;                      // [RL16] [RL17]

  // error flags: a new error in the clearing read cycle survives
  wire ovr_d = rx_overrun_i || (ovr_q && !rd_lsr);
  wire frm_d = rx_frame_err_i || (frm_q && !rd_lsr);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
    end else begin
      ovr_q <= ovr_d;
      frm_q <= frm_d;
    end
  end

  // configuration registers, cleared by a card reset command
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_q <= `HPAD_BAUD_RST;
      ier_q  <= `HPAD_IER_RST;
      lcr_q  <= `HPAD_LCR_RST;
    end else if (cpu_rst) begin
      baud_q <= `HPAD_BAUD_RST;
      ier_q  <= `HPAD_IER_RST;
      lcr_q  <= `HPAD_LCR_RST;
    end else begin
      baud_q <= wr_baud ? wdata : baud_q;                         // [RL10]
      ier_q  <= wr_ier ? wdata[3:0] : ier_q;                      // [RL11]
      lcr_q  <= wr_lcr ? wdata : lcr_q;                           // [RL13]
    end
  end

  // read data and drive enable, one cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q    <= 8'h00;
      rdata_oe_q <= 1'b0;
      card_rst_q <= 1'b0;
    end else begin
      rdata_q    <= rd_hit ? rd_val : 8'h00;
      rdata_oe_q <= rd_hit;                                       // [RL1]
      card_rst_q <= cpu_rst;                                      // [RL12]
    end
  end

  assign io_rdata_o    = rdata_q;
  assign io_rdata_oe_o = rdata_oe_q;
  assign baud_sel_o    = baud_q;
  assign line_ctrl_o   = lcr_q;
  assign card_reset_o  = card_rst_q;

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_decode_miss: assert property (  // [RL1]
    io_req_i.rd && io_req_i.addr[9:3] != ~base_jumper_fitted_i |=> !io_rdata_oe_o)
    else $error("read outside the window was answered");

  chk_jumper_sense: assert property (  // [RL2]
    io_req_i.rd && io_req_i.addr[9:3] == ~base_jumper_fitted_i |=> io_rdata_oe_o)
    else $error("read inside the window was not answered");

  chk_id_readback: assert property (  // [RL16]
    rd_hit && ofs == `HPAD_OFS_ID |=> io_rdata_o == CARD_ID)
    else $error("card code read back wrong");

  chk_spare_zero: assert property (  // [RL17]
    rd_hit && ofs == `HPAD_OFS_SPARE |=> io_rdata_o == 8'h00)
    else $error("unassigned offset did not read zero");

  chk_rx_pop: assert property (  // [RL8]
    rd_rx |=> io_rdata_o == $past(rx_out_data))
    else $error("receive read returned wrong byte");

  chk_tx_push: assert property (  // [RL9]
    wr_tx && !tx_valid_o |=> tx_valid_o && tx_data_o == $past(wdata))
    else $error("written byte did not reach transmit buffer");

  chk_baud_bank: assert property (  // [RL10]
    wr_hit && ofs == `HPAD_OFS_DATA && bank && !tx_valid_o
      |=> baud_sel_o == $past(wdata) && !tx_valid_o)
    else $error("baud write misrouted");

  chk_ier_write: assert property (  // [RL11]
    wr_ier ##1 !wr_hit ##1 rd_hit && ofs == `HPAD_OFS_IER && !bank
      |=> io_rdata_o == {4'h0, $past(wdata[3:0], 3)})
    else $error("interrupt enable read back wrong");

  chk_card_reset: assert property (  // [RL12]
    cpu_rst |=> card_reset_o && baud_sel_o == 8'h00 && line_ctrl_o == 8'h00
      ##1 !card_reset_o)
    else $error("card reset command misbehaved");

  chk_lcr_write: assert property (  // [RL13]
    wr_lcr && !cpu_rst |=> line_ctrl_o == $past(wdata))
    else $error("line control not written");

  chk_ovr_clear: assert property (  // [RL14]
    ovr_q && rd_lsr && !rx_overrun_i |=> io_rdata_o[1] && !ovr_q)
    else $error("overrun flag not shown or not cleared");

  chk_irq_route: assert property (  // [RL5]
    ier_q[`HPAD_IER_MS] && remote_irq_i |-> irq_line_o == irq_route_fitted_i)
    else $error("interrupt not on routed line");

  chk_mode_hold: assert property (  // [RL6]
    option_jumper_fitted_i[0] && !rsp_complete_i && rd_lsr |=> !io_rdata_o[0])
    else $error("response mode showed data early");

  chk_idle_quiet: assert property (  // [RL1]
    !rd_hit |=> !io_rdata_oe_o && io_rdata_o == 8'h00)
    else $error("data bus driven without a decoded read");

  chk_write_silent: assert property (  // [RL1]
    io_req_i.wr && !io_req_i.rd |=> !io_rdata_oe_o)
    else $error("a write drove the data bus");

  chk_bank_ier_read: assert property (  // [RL15]
    rd_hit && ofs == `HPAD_OFS_IER && bank |=> io_rdata_o == 8'h00)
    else $error("offset 1 with bank bit set did not read zero");

  chk_bank_ier_hold: assert property (  // [RL15]
    wr_hit && ofs == `HPAD_OFS_IER && bank |=> $stable(ier_q))
    else $error("offset 1 write with bank bit set reached the enables");

  chk_ro_ignored: assert property (  // [RL17]
    wr_hit && ofs >= `HPAD_OFS_SPARE
      |=> $stable(baud_q) && $stable(ier_q) && $stable(lcr_q))
    else $error("write to a read-only offset changed a register");

  chk_opt1_ignored: assert property (  // [RL7]
    $changed(option_jumper_fitted_i[1]) && $stable(option_jumper_fitted_i[0])
      |-> $stable(mode_o))
    else $error("option jumper 1 changed the mode");

  chk_char_mode: assert property (  // [RL6]
    !option_jumper_fitted_i[0] && rx_out_valid && rd_lsr |=> io_rdata_o[0])
    else $error("character mode hid a buffered byte");

  chk_iir_idle: assert property (  // [RL12]
    rd_hit && ofs == `HPAD_OFS_IIR && ier_q == `HPAD_IER_RST
      |=> io_rdata_o == `HPAD_IIR_NONE)
    else $error("identification showed a masked interrupt");

  chk_iir_line_first: assert property (  // [RL12]
    rd_hit && ofs == `HPAD_OFS_IIR && ier_q[`HPAD_IER_LS] && (ovr_q || frm_q)
      |=> io_rdata_o == `HPAD_IIR_LS)
    else $error("line status interrupt not given first place");

  chk_irq_masked: assert property (  // [RL5]
    ier_q == `HPAD_IER_RST |-> irq_line_o == '0)
    else $error("interrupt line raised with every source masked");

  chk_irq_unrouted: assert property (  // [RL5]
    (irq_line_o & ~irq_route_fitted_i) == '0)
    else $error("interrupt on a line without a routing jumper");

  chk_rx_flush: assert property (  // [RL12]
    wr_rstc && wdata[`HPAD_RSTC_RXF] |=> !rx_out_valid)
    else $error("receive buffer not emptied by reset command");

  chk_tx_flush: assert property (  // [RL12]
    wr_rstc && wdata[`HPAD_RSTC_TXF] |=> !tx_valid_o)
    else $error("transmit buffer not emptied by reset command");

  chk_tx_full_drop: assert property (  // [RL9]
    wr_tx && !tx_in_ready && !tx_ready_i |=> !tx_in_ready && $stable(tx_data_o))
    else $error("write into a full transmit buffer disturbed it");

  cov_id_read: cover property (rd_hit && ofs == `HPAD_OFS_ID);
  cov_tx_full: cover property (wr_tx && !tx_in_ready);
  cov_rx_read: cover property (rd_rx ##2 rd_rx);
  cov_baud_write: cover property (wr_baud);
  cov_card_rst: cover property (cpu_rst);
endmodule

/* File: verif/hpad_card_model.sv */
// Purpose: card side byte streams facing the host port
// Assumes: bench pushes receive bytes between clock edges
// Notes:   stall_i holds transmit ready low so the buffer fills
`timescale 1ns/10ps
module hpad_card_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // receive stream toward the host port
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output logic [7:0]      rx_data_o,
  // transmit stream from the host port
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       stall_i
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_seen[$];
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      tx_ready_o <= 1'b0;
    end else begin
      if (rx_valid_o && rx_ready_i) begin
        void'(rx_q.pop_front());
      end
      if (rx_q.size() > 0) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= rx_q[0];
      end else begin
        rx_valid_o <= 1'b0;
        // a released line keeps changing, so stale data never looks good
        rx_data_o  <= ~rx_data_o;
      end
      if (tx_valid_i && tx_ready_o) begin
        tx_seen.push_back(tx_data_i);
      end
      // slow on purpose: ready at most every other cycle
      tx_ready_o <= ~stall_i & ~tx_ready_o;
    end
  end
endmodule

/* File: verif/host_port_address_decode_bench.sv */
// Purpose: self-checking bench of the host port decode
// Assumes: one host access at a time, strobes one cycle wide
// Notes:   expected stream bytes come from queues kept beside the design; line control and baud values are random
`timescale 1ns/10ps
`include "hpad_regs.svh"
module host_port_address_decode_bench;
  import hpad_pkg::*;
  localparam logic [7:0] ID = 8'h3C;  // arbitrary card code
  logic          sys_clk_i, sys_rst_i, oe, rxv, rxr, txv, txr, cres;
  logic          cpl, ovr, fre, rirq, stall;
  hpad_bus_req_s req;
  hpad_mode_e    mode;
  logic [7:0]    rdata, baud, lcr_o, txd, rxd, route, irq, v, w, x;
  logic [6:0]    base, cur;
  logic [1:0]    opt;
  logic [7:0]    exp_rx[$];
  logic [7:0]    exp_tx[$];
  int            miscompares, tests_run;

  hpad_port #(.IRQ_LINES(8), .CARD_ID(ID)) uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .io_req_i(req),
    .io_rdata_o(rdata), .io_rdata_oe_o(oe), .base_jumper_fitted_i(~base),
    .irq_route_fitted_i(route), .option_jumper_fitted_i(opt), .irq_line_o(irq),
    .rx_valid_i(rxv), .rx_ready_o(rxr), .rx_data_i(rxd), .rsp_complete_i(cpl),
    .rx_overrun_i(ovr), .rx_frame_err_i(fre), .remote_irq_i(rirq),
    .tx_valid_o(txv), .tx_ready_i(txr), .tx_data_o(txd), .mode_o(mode),
    .baud_sel_o(baud), .line_ctrl_o(lcr_o), .card_reset_o(cres));
  hpad_card_model model (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .rx_valid_o(rxv), .rx_ready_i(rxr),
    .rx_data_o(rxd), .tx_valid_i(txv), .tx_ready_o(txr), .tx_data_i(txd), .stall_i(stall));

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one strobe, then the answer is taken one edge later
  task automatic acc(input logic [2:0] ofs, input logic wr, input logic [7:0] wd);
    @(posedge sys_clk_i);
    req <= '{addr: {cur, ofs}, rd: !wr, wr: wr, wdata: wd};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    #1;
    v = rdata;
    chk({7'd0, oe}, {7'd0, !wr && cur == base});
    if (cur != base) chk(v, 8'h00);
  endtask
  task automatic rd(input logic [2:0] ofs, input logic [7:0] e);
    acc(ofs, 1'b0, 8'h00);
    chk(v, e);
  endtask
  task automatic push(input logic [7:0] b);
    @(negedge sys_clk_i);
    model.rx_q.push_back(b);
    exp_rx.push_back(b);
  endtask
  task automatic pulse_err();
    @(posedge sys_clk_i);
    ovr <= 1'b1;
    fre <= 1'b1;
    @(posedge sys_clk_i);
    ovr <= 1'b0;
    fre <= 1'b0;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h72a6));
    base = 7'($urandom_range(0, 127));  // base below 3FF, ends in 0 or 8
    cur = base;
    route = 8'h01 << $urandom_range(0, 7);
    req = '0;
    {cpl, ovr, fre, rirq, stall, opt} = 7'b0000100;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(`HPAD_OFS_ID, ID);
    rd(`HPAD_OFS_LCR, `HPAD_LCR_RST);
    rd(`HPAD_OFS_IIR, `HPAD_IIR_NONE);
    for (int o = 4; o < 8; o++) acc(3'(o), 1'b1, 8'hFF);
    rd(`HPAD_OFS_ID, ID);
    rd(`HPAD_OFS_SPARE, 8'h00);
    rd(`HPAD_OFS_LSR, 8'h60);
    rd(`HPAD_OFS_MSR, 8'h00);
    $display("test reset_map done");
    for (int i = 0; i < 7; i++) begin
      cur = base ^ (7'h01 << i);
      acc(`HPAD_OFS_ID, 1'b0, 8'h00);
      acc(`HPAD_OFS_LCR, 1'b1, 8'h1F);
    end
    cur = base;
    rd(`HPAD_OFS_LCR, 8'h00);
    $display("test window done");
    w = 8'($urandom) & 8'h7F;
    acc(`HPAD_OFS_LCR, 1'b1, w);
    rd(`HPAD_OFS_LCR, w);
    chk(lcr_o, w);
    acc(`HPAD_OFS_IER, 1'b1, 8'hFF);
    rd(`HPAD_OFS_IER, 8'h0F);
    acc(`HPAD_OFS_IER, 1'b1, 8'h00);
    acc(`HPAD_OFS_LCR, 1'b1, w | 8'h80);
    x = 8'($urandom);
    acc(`HPAD_OFS_DATA, 1'b1, x);
    rd(`HPAD_OFS_DATA, x);
    chk(baud, x);
    chk({7'd0, txv}, 8'h00);
    acc(`HPAD_OFS_IER, 1'b1, 8'h0F);
    rd(`HPAD_OFS_IER, 8'h00);
    acc(`HPAD_OFS_LCR, 1'b1, w);
    rd(`HPAD_OFS_IER, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      w = 8'($urandom);
      acc(`HPAD_OFS_DATA, 1'b1, w);
      if (i != 2) exp_tx.push_back(w);
      if (i == 2) begin
        chk(txd, exp_tx[0]);
        rd(`HPAD_OFS_LSR, 8'h00);
        acc(`HPAD_OFS_IIR, 1'b1, 8'h04);
        exp_tx.delete();
        rd(`HPAD_OFS_LSR, 8'h60);
      end
    end
    chk(txd, exp_tx[0]);
    @(posedge sys_clk_i);
    stall <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    chk(8'(model.tx_seen.size()), 8'd2);
    for (int i = 0; i < 2; i++) chk(model.tx_seen[i], exp_tx[i]);
    rd(`HPAD_OFS_LSR, 8'h60);
    $display("test transmit done");
    for (int i = 0; i < 3; i++) push(8'($urandom));
    repeat (8) @(posedge sys_clk_i);
    rd(`HPAD_OFS_LSR, 8'h61);
    chk({7'd0, rxr}, 8'h00);
    for (int i = 0; i < 3; i++) rd(`HPAD_OFS_DATA, exp_rx.pop_front());
    rd(`HPAD_OFS_LSR, 8'h60);
    for (int i = 0; i < 2; i++) push(8'($urandom));
    repeat (6) @(posedge sys_clk_i);
    acc(`HPAD_OFS_IIR, 1'b1, 8'h02);
    exp_rx.delete();
    rd(`HPAD_OFS_LSR, 8'h60);
    $display("test receive done");
    @(posedge sys_clk_i);
    opt <= 2'b01;
    push(8'h5C);
    repeat (6) @(posedge sys_clk_i);
    chk(8'(mode), 8'(HPAD_MODE_BLOCK));
    rd(`HPAD_OFS_LSR, 8'h60);
    @(posedge sys_clk_i);
    cpl <= 1'b1;
    opt <= 2'b11;
    rd(`HPAD_OFS_LSR, 8'h61);
    chk(8'(mode), 8'(HPAD_MODE_BLOCK));
    rd(`HPAD_OFS_DATA, exp_rx.pop_front());
    @(posedge sys_clk_i);
    opt <= 2'b10;
    #1;
    chk(8'(mode), 8'(HPAD_MODE_CHAR));
    $display("test mode done");
    acc(`HPAD_OFS_IER, 1'b1, 8'h0F);
    rd(`HPAD_OFS_IIR, `HPAD_IIR_THRE);
    chk(irq, route);
    pulse_err();
    rd(`HPAD_OFS_IIR, `HPAD_IIR_LS);
    rd(`HPAD_OFS_LSR, 8'h6A);
    rd(`HPAD_OFS_LSR, 8'h60);
    @(posedge sys_clk_i);
    rirq <= 1'b1;
    acc(`HPAD_OFS_IER, 1'b1, 8'h08);
    rd(`HPAD_OFS_IIR, `HPAD_IIR_MS);
    rd(`HPAD_OFS_MSR, 8'h10);
    chk(irq, route);
    acc(`HPAD_OFS_IER, 1'b1, 8'h00);
    chk(irq, 8'h00);
    rirq <= 1'b0;
    $display("test interrupt done");
    acc(`HPAD_OFS_LCR, 1'b1, 8'h03);
    acc(`HPAD_OFS_IIR, 1'b1, 8'h10);
    chk({7'd0, cres}, 8'h00);
    acc(`HPAD_OFS_LCR, 1'b1, 8'h83);
    acc(`HPAD_OFS_IIR, 1'b1, 8'h10);
    chk({7'd0, cres}, 8'h01);
    rd(`HPAD_OFS_LCR, 8'h00);
    chk(baud, 8'h00);
    $display("test card_reset done");
    give_verdict();
  end
endmodule
